// ===== lamp_boost_pkg.sv
// Constants shared by the lamp overdrive controller and its testbench; the pin synchroniser uses none of them.
// Assumes a 25 MHz system clock and a two-wire serial management bus at the pins.
package lamp_boost_pkg;
	// Register map and field layout of the overdrive control register.
	localparam logic [7:0] ADDR_OVERDRIVE_CONTROL = 8'hf7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam int LEVEL_LSB = 0;
	localparam int LEVEL_W = 3;
	localparam int ENABLE_BIT = 3;
	localparam int LIMIT_LSB = 4;
	localparam int LIMIT_W = 4;
	// Each timeout step is a power of two of lamp-oscillator cycles.
	localparam int LIMIT_SHIFT = 22;
	// Upper five bits of the bus address; the low two come from the address pins.
	localparam logic [4:0] BUS_ADDR_HI = 5'h14;
	// Bits per byte on the serial bus, counted by scl rising edges.
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Nonvolatile commit time, in microseconds, and its length in clock cycles.
	localparam int CLK_HZ = 25000000;
	localparam int T_NV_WRITE_US = 10000;
	localparam int NV_WRITE_CYCLES = T_NV_WRITE_US * (CLK_HZ / 1000000);
	// Synchronised pin vector layout.
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_REQ = 2;
	localparam int PIN_OSC = 3;
	localparam int PIN_ADDR0 = 4;
	localparam int PIN_ADDR1 = 5;
	localparam int PIN_COUNT = 6;
endpackage

// ===== pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes every bit arrives from outside the system clock domain.
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_i, // System clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic ce_i, // Clock enable; state freezes while low.
	input wire logic [WIDTH-1:0] pin_i, // Raw asynchronous pins.
	output logic [WIDTH-1:0] level_o // Filtered levels.
);
	logic [WIDTH-1:0] s1_r, s2_r, s3_r, q_r;
	logic [WIDTH-1:0] q_nxt;

	// A new level counts only once the second and third stages agree.
	// Each bit is its own continuous assignment so every bit keeps exactly one driver.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		assign q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
	end

	// The first stage feeds only the second, keeping metastability contained.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r <= '0;
		end else if (ce_i) begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= q_nxt;
		end
	end

	assign level_o = q_r;
endmodule

// ===== lamp_overdrive_timeout_ctrl.sv
// Lamp current overdrive control: serial-bus register slave, boost enable and timeout.
// Assumes open-drain bus pins resolved outside and a lamp oscillator square wave on a pin.
`timescale 1ns/10ps
module lamp_overdrive_timeout_ctrl
	import lamp_boost_pkg::*;
#(
	parameter int TIMEOUT_SHIFT = LIMIT_SHIFT,
	parameter int NV_WRITE_CLKS = NV_WRITE_CYCLES
) (
	input wire logic sys_clk_i, // System clock, 25 MHz.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic ce_i, // Clock enable; all state freezes while low.
	input wire logic scl_i, // Serial bus clock pin.
	input wire logic sda_i, // Serial bus data pin, level seen.
	output logic sda_o, // Serial bus data drive value, always low.
	output logic sda_oe_o, // High while this block pulls the data line low.
	input wire logic [1:0] bus_addr_pin_i, // Address select pins.
	input wire logic boost_request_pin_i, // External boost request, active high.
	input wire logic lamp_osc_i, // Lamp oscillator square wave.
	output logic boost_active_o, // Lamp runs above nominal current.
	output logic [3:0] boost_eighths_o, // Boost in eighths of nominal, zero when off.
	output logic nv_busy_o // Nonvolatile commit in progress.
);
	localparam int CNT_W = TIMEOUT_SHIFT + LIMIT_W;
	localparam int BUSY_W = $clog2(NV_WRITE_CLKS + 1);

	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} bus_state_e;

	logic [PIN_COUNT-1:0] pin_q;
	logic scl_d_r, sda_d_r, osc_d_r;
	logic scl_rise, scl_fall, bus_start, bus_stop, osc_edge, addr_match;
	bus_state_e st_r, st_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [1:0] idx_r, idx_nxt;
	logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, ctrl_r, ctrl_nxt, rdata;
	logic rw_r, rw_nxt, commit_r, commit_nxt, oe_r, oe_nxt;
	logic [BUSY_W-1:0] busy_r, busy_nxt;
	logic eff, eff_d_r, expired_r, expired_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt, target;
	logic [LIMIT_W-1:0] limit;
	logic [LEVEL_W-1:0] level;
	logic active_r, active_nxt, busy_o_r;
	logic [3:0] eighths_r, eighths_nxt;

	// All pins cross into the clock domain through the filtered synchroniser.
	pin_sync #(.WIDTH(PIN_COUNT)) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pin_i({bus_addr_pin_i, lamp_osc_i, boost_request_pin_i, sda_i, scl_i}),
		.level_o(pin_q)
	);

	// Bus conditions and the lamp edge, all taken from filtered levels.
	assign scl_rise = pin_q[PIN_SCL] & ~scl_d_r;
	assign scl_fall = ~pin_q[PIN_SCL] & scl_d_r;
	assign bus_start = pin_q[PIN_SCL] & scl_d_r & sda_d_r & ~pin_q[PIN_SDA];
	assign bus_stop = pin_q[PIN_SCL] & scl_d_r & ~sda_d_r & pin_q[PIN_SDA];
	assign osc_edge = pin_q[PIN_OSC] & ~osc_d_r;
	assign addr_match = (sh_r[7:3] == BUS_ADDR_HI) && (sh_r[2:1] == {pin_q[PIN_ADDR1], pin_q[PIN_ADDR0]});
	// Unmapped register addresses read as zero and silently drop writes.
	assign rdata = (ptr_r == ADDR_OVERDRIVE_CONTROL) ? ctrl_r : UNMAPPED_READ;
	assign limit = ctrl_r[LIMIT_LSB +: LIMIT_W];
	assign level = ctrl_r[LEVEL_LSB +: LEVEL_W];
	assign eff = ctrl_r[ENABLE_BIT] | pin_q[PIN_REQ];
	assign target = {limit, {TIMEOUT_SHIFT{1'b0}}};

	// Bus slave: receive address, register pointer and data, or send read data.
	always_comb begin
		st_nxt = st_r;
		bit_nxt = bit_r;
		idx_nxt = idx_r;
		sh_nxt = sh_r;
		ptr_nxt = ptr_r;
		ctrl_nxt = ctrl_r;
		rw_nxt = rw_r;
		commit_nxt = commit_r;
		oe_nxt = oe_r;
		busy_nxt = busy_r;
		if (ce_i) begin
			if (busy_r != '0) begin
				busy_nxt = busy_r - 1'b1;
			end
			if (bus_start) begin
				st_nxt = ST_RX;
				bit_nxt = '0;
				idx_nxt = '0;
				oe_nxt = 1'b0;
			end else if (bus_stop) begin
				st_nxt = ST_IDLE;
				oe_nxt = 1'b0;
				// The commit time only starts once the host has closed the frame.
				if (commit_r) begin
					busy_nxt = BUSY_W'(NV_WRITE_CLKS);
					commit_nxt = 1'b0;
				end
			end else begin
				unique case (st_r)
					ST_IDLE: begin
					end
					ST_RX: begin
						if (scl_rise) begin
							sh_nxt = {sh_r[6:0], pin_q[PIN_SDA]};
							bit_nxt = bit_r + 1'b1;
						end else if (scl_fall && bit_r == BITS_PER_BYTE) begin
							bit_nxt = '0;
							st_nxt = ST_ACK;
							oe_nxt = 1'b1;
							if (idx_r == 2'h0) begin
								rw_nxt = sh_r[0];
								if (!addr_match || busy_r != '0) begin
									st_nxt = ST_IDLE;
									oe_nxt = 1'b0;
								end
							end else if (idx_r == 2'h1) begin
								ptr_nxt = sh_r;
							end else if (ptr_r == ADDR_OVERDRIVE_CONTROL) begin
								ctrl_nxt = sh_r;
								commit_nxt = 1'b1;
							end
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							idx_nxt = (idx_r == 2'h2) ? idx_r : idx_r + 1'b1;
							if (rw_r) begin
								st_nxt = ST_TX;
								sh_nxt = rdata;
								oe_nxt = ~rdata[7];
							end else begin
								st_nxt = ST_RX;
								oe_nxt = 1'b0;
							end
						end
					end
					ST_TX: begin
						if (scl_rise) begin
							bit_nxt = bit_r + 1'b1;
						end else if (scl_fall) begin
							if (bit_r == BITS_PER_BYTE) begin
								bit_nxt = '0;
								oe_nxt = 1'b0;
								st_nxt = ST_RACK;
							end else begin
								sh_nxt = {sh_r[6:0], 1'b0};
								oe_nxt = ~sh_r[6];
							end
						end
					end
					ST_RACK: begin
						// A not-acknowledge ends the read; we then wait for stop or start.
						if (scl_rise && pin_q[PIN_SDA]) begin
							st_nxt = ST_IDLE;
						end else if (scl_fall) begin
							st_nxt = ST_TX;
							sh_nxt = rdata;
							oe_nxt = ~rdata[7];
						end
					end
				endcase
			end
		end
	end

	// Boost timer: counts lamp edges while enabled, latches expiry until re-enable.
	always_comb begin
		cnt_nxt = cnt_r;
		expired_nxt = expired_r;
		active_nxt = active_r;
		eighths_nxt = eighths_r;
		if (ce_i) begin
			if (!eff || !eff_d_r) begin
				cnt_nxt = '0;
				expired_nxt = 1'b0;
			end else if (!expired_r && limit != '0 && osc_edge) begin
				cnt_nxt = cnt_r + 1'b1;
				// Compare as at-least so a limit lowered mid-run still ends the boost.
				if ((cnt_r + CNT_W'(1)) >= target) begin
					expired_nxt = 1'b1;
				end
			end
			active_nxt = eff & ~expired_r;
			eighths_nxt = active_nxt ? {1'b0, level} + 4'h1 : 4'h0;
		end
	end

	// State registers; the clock enable is folded into the next values, except for the pin and enable delay registers, which it gates here.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_r <= ST_IDLE;
			bit_r <= '0;
			idx_r <= '0;
			sh_r <= '0;
			ptr_r <= '0;
			ctrl_r <= CTRL_RESET;
			rw_r <= 1'b0;
			commit_r <= 1'b0;
			oe_r <= 1'b0;
			busy_r <= '0;
			scl_d_r <= 1'b0;
			sda_d_r <= 1'b0;
			osc_d_r <= 1'b0;
			eff_d_r <= 1'b0;
			cnt_r <= '0;
			expired_r <= 1'b0;
			active_r <= 1'b0;
			eighths_r <= '0;
			busy_o_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			bit_r <= bit_nxt;
			idx_r <= idx_nxt;
			sh_r <= sh_nxt;
			ptr_r <= ptr_nxt;
			ctrl_r <= ctrl_nxt;
			rw_r <= rw_nxt;
			commit_r <= commit_nxt;
			oe_r <= oe_nxt;
			busy_r <= busy_nxt;
			cnt_r <= cnt_nxt;
			expired_r <= expired_nxt;
			active_r <= active_nxt;
			eighths_r <= eighths_nxt;
			busy_o_r <= (busy_nxt != '0);
			if (ce_i) begin
				scl_d_r <= pin_q[PIN_SCL];
				sda_d_r <= pin_q[PIN_SDA];
				osc_d_r <= pin_q[PIN_OSC];
				eff_d_r <= eff;
			end
		end
	end

	// The data pin is open drain: only a low is ever driven.
	assign sda_o = 1'b0;
	assign sda_oe_o = oe_r;
	assign boost_active_o = active_r;
	assign boost_eighths_o = eighths_r;
	assign nv_busy_o = busy_o_r;

	// Checks on the block's own behaviour.
	sequence s_addr_byte_done;
		ce_i && st_r == ST_RX && !bus_start && !bus_stop && scl_fall && bit_r == BITS_PER_BYTE && idx_r == 2'h0;
	endsequence
	sequence s_ctrl_write;
		ce_i && st_r == ST_RX && !bus_start && !bus_stop && scl_fall && bit_r == BITS_PER_BYTE
			&& idx_r == 2'h2 && ptr_r == ADDR_OVERDRIVE_CONTROL;
	endsequence

	a_level_to_eighths: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && eff && !expired_r |=> boost_active_o && boost_eighths_o == {1'b0, $past(level)} + 4'h1)
		else $error("Boost level does not follow the level code.");
	a_enable_off_nominal: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && !ctrl_r[ENABLE_BIT] && !pin_q[PIN_REQ] |=> !boost_active_o && boost_eighths_o == 4'h0)
		else $error("Boost active with enable bit and pin both off.");
	a_zero_limit_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && limit == '0 && !expired_r |=> !expired_r)
		else $error("Timeout fired while disabled.");
	a_limit_expires: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && eff && eff_d_r && !expired_r && limit != '0 && osc_edge && (cnt_r + CNT_W'(1)) == target
		|=> expired_r ##1 (!boost_active_o || !$past(ce_i))) // Output is registered from expired_r, one edge later.
		else $error("Boost did not end at the timeout.");
	a_ctrl_write_stores: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_ctrl_write |=> ctrl_r == $past(sh_r) && commit_r)
		else $error("Write to the control register not stored.");
	a_busy_nacks_addr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_addr_byte_done ##0 busy_r != '0 |=> !sda_oe_o && st_r == ST_IDLE)
		else $error("Bus address acknowledged during commit.");
	a_stop_starts_busy: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && bus_stop && commit_r |=> busy_r == BUSY_W'(NV_WRITE_CLKS) ##1 nv_busy_o)
		else $error("Commit time did not start at stop.");
	a_expiry_sticks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && expired_r && eff |=> !boost_active_o)
		else $error("Boost returned after timeout without re-enable.");
	a_disable_rearms: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && !eff |=> !expired_r && cnt_r == '0)
		else $error("Timeout not rearmed by dropping enable.");
endmodule

// ===== tb.sv
// Self-checking testbench for the lamp overdrive controller: serial register access, boost level and timeout.
// Assumes the package constants and a master that resolves the open-drain data line itself.
`timescale 1ns/10ps
module tb;
	import lamp_boost_pkg::*;
	localparam int TSH = 4;
	localparam int NVC = 400;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic scl_m = 1'b1;
	logic sda_m = 1'b1;
	logic req = 1'b0;
	logic osc = 1'b0;
	logic ce = 1'b1;
	logic [1:0] apin = 2'h2;
	logic sda_w, sda_o, sda_oe_o, boost_active_o, nv_busy_o;
	logic [3:0] boost_eighths_o;
	int failures = 0;
	int checks_done = 0;
	// The data line is wired-AND of the master and the block's pull-down.
	assign sda_w = sda_m & ~sda_oe_o;
	always #20 sys_clk_i = ~sys_clk_i;
	lamp_overdrive_timeout_ctrl #(.TIMEOUT_SHIFT(TSH), .NV_WRITE_CLKS(NVC)) u_dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce), .scl_i(scl_m), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .bus_addr_pin_i(apin), .boost_request_pin_i(req), .lamp_osc_i(osc),
		.boost_active_o(boost_active_o), .boost_eighths_o(boost_eighths_o), .nv_busy_o(nv_busy_o));
	// Inputs only ever change just after a falling edge.
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One bit slot; data moves two cycles after scl falls so it never looks like a start or stop.
	task automatic bit_x(input logic b, output logic s);
		tick(2);
		sda_m = b;
		tick(8);
		scl_m = 1'b1;
		tick(5);
		s = sda_w;
		tick(5);
		scl_m = 1'b0;
	endtask
	task automatic start();
		tick(2);
		sda_m = 1'b1;
		tick(8);
		scl_m = 1'b1;
		tick(10);
		sda_m = 1'b0;
		tick(10);
		scl_m = 1'b0;
	endtask
	task automatic stop();
		tick(2);
		sda_m = 1'b0;
		tick(8);
		scl_m = 1'b1;
		tick(10);
		sda_m = 1'b1;
		tick(10);
	endtask
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(b[i], s);
		bit_x(1'b1, s);
		ack = ~s;
	endtask
	task automatic rd_byte(output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(1'b1, s);
	endtask
	// Register pointer goes right after the address byte, then the data.
	task automatic write_reg(input logic [7:0] ra, input logic [7:0] d, input logic [1:0] ap, output logic ack);
		logic a1, a2, a3;
		start();
		wr_byte({BUS_ADDR_HI, ap, 1'b0}, a1);
		wr_byte(ra, a2);
		wr_byte(d, a3);
		stop();
		ack = a1 & a2 & a3;
	endtask
	task automatic read_reg(input logic [7:0] ra, output logic [7:0] d);
		logic a;
		start();
		wr_byte({BUS_ADDR_HI, apin, 1'b0}, a);
		wr_byte(ra, a);
		start();
		wr_byte({BUS_ADDR_HI, apin, 1'b1}, a);
		rd_byte(d);
		stop();
	endtask
	// Bounded wait for the commit time to run out.
	task automatic wait_idle();
		for (int i = 0; i < 4 * NVC; i++) begin
			if (nv_busy_o === 1'b0)
				return;
			tick(1);
		end
		failures++;
		test_done();
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			osc = 1'b1;
			tick(4);
			osc = 1'b0;
			tick(4);
		end
	endtask
	task automatic t_reset();
		logic [7:0] d;
		read_reg(ADDR_OVERDRIVE_CONTROL, d);
		chk(d, CTRL_RESET);
		chk({4'h0, boost_eighths_o}, 8'h00);
		chk({7'h0, sda_o}, 8'h00);
	endtask
	// Every level code with the enable bit set, then read the last one back.
	task automatic t_levels();
		logic a;
		logic [7:0] d;
		for (int n = 0; n < 8; n++) begin
			write_reg(ADDR_OVERDRIVE_CONTROL, 8'h08 | 8'(n), apin, a);
			chk({7'h0, a}, 8'h01);
			wait_idle();
			chk({4'h0, boost_eighths_o}, 8'(n + 1));
			chk({7'h0, boost_active_o}, 8'h01);
		end
		read_reg(ADDR_OVERDRIVE_CONTROL, d);
		chk(d, 8'h0f);
	endtask
	// The address is refused while a commit runs; clearing the enable returns to nominal.
	task automatic t_busy();
		logic a;
		write_reg(ADDR_OVERDRIVE_CONTROL, 8'h00, apin, a);
		start();
		wr_byte({BUS_ADDR_HI, apin, 1'b0}, a);
		stop();
		chk({7'h0, a}, 8'h00);
		chk({7'h0, nv_busy_o}, 8'h01);
		wait_idle();
		chk({4'h0, boost_eighths_o}, 8'h00);
	endtask
	task automatic t_refuse();
		logic a;
		logic [7:0] d;
		write_reg(ADDR_OVERDRIVE_CONTROL, 8'h0f, 2'h1, a);
		chk({7'h0, a}, 8'h00);
		write_reg(8'h10, 8'h5a, apin, a);
		read_reg(8'h10, d);
		chk(d, UNMAPPED_READ);
		read_reg(ADDR_OVERDRIVE_CONTROL, d);
		chk(d, 8'h00);
	endtask
	// Pin enable with no limit, then a limit of two steps, expiry and re-arm by the pin.
	task automatic t_timeout();
		logic a;
		write_reg(ADDR_OVERDRIVE_CONTROL, 8'h05, apin, a);
		wait_idle();
		req = 1'b1;
		tick(10);
		pulse(40);
		chk({4'h0, boost_eighths_o}, 8'h06);
		req = 1'b0;
		write_reg(ADDR_OVERDRIVE_CONTROL, 8'h25, apin, a);
		wait_idle();
		req = 1'b1;
		tick(10);
		pulse((2 << TSH) - 1);
		chk({7'h0, boost_active_o}, 8'h01);
		pulse(1);
		tick(8);
		chk({7'h0, boost_active_o}, 8'h00);
		chk({4'h0, boost_eighths_o}, 8'h00);
		pulse(4);
		chk({7'h0, boost_active_o}, 8'h00);
		req = 1'b0;
		tick(10);
		req = 1'b1;
		tick(10);
		chk({7'h0, boost_active_o}, 8'h01);
		req = 1'b0;
	endtask
	// Clock enable low freezes everything, synchroniser included, so a pin drop lands only after it returns.
	task automatic t_freeze();
		tick(10);
		req = 1'b1;
		tick(10);
		chk({7'h0, boost_active_o}, 8'h01);
		ce = 1'b0;
		req = 1'b0;
		tick(20);
		chk({7'h0, boost_active_o}, 8'h01);
		ce = 1'b1;
		tick(10);
		chk({7'h0, boost_active_o}, 8'h00);
	endtask
	initial begin
		tick(20);
		rst_i = 1'b0;
		tick(10);
		t_reset();
		t_levels();
		t_busy();
		t_refuse();
		t_timeout();
		t_freeze();
		test_done();
	end
endmodule
